// ---- hdl/keying_defines.svh ----
/*
 register offsets, field positions, reset values and timing constants of the keying control block.
 assumes a 10 MHz clock and a 32-bit axi4-lite register bus.
*/
`ifndef KEYING_DEFINES_SVH
`define KEYING_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL        5'h00
`define OFF_WAVE        5'h04
`define OFF_CARRIER     5'h08
`define OFF_HOP         5'h0C
`define OFF_RATE        5'h10
`define OFF_PHASE       5'h14
`define OFF_LEVEL       5'h18
`define OFF_STATUS      5'h1C
// ----------------------------------------
// ctrl fields
// ----------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_SWEEP      4
// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_REJ_MODE     1
`define ST_REJ_WAVE     2
`define ST_REJ_FREQ     3
`define ST_REJ_RATE     4
`define ST_REJ_PHASE    5
// ----------------------------------------
// rates and limits, frequencies in millihertz except CLK_HZ in hertz
// ----------------------------------------
`define CLK_HZ          10000000
`define CLK_MHZ_UNITS   64'd10000000000
`define RATE_MIN_MHZ    32'd2
`define RATE_MAX_MHZ    32'd100000000
`define RATE_DEF_MHZ    32'd10000
`define HOP_DEF_MHZ     32'd100000
`define CARRIER_DEF_MHZ 32'd1000000
`define FAST_MAX_MHZ    64'd20000000000
`define SLOW_MAX_MHZ    64'd200000000
`define PHASE_MAX_DEG   9'd360
`define PHASE_DEF_DEG   9'd180
`define LEVEL_DEF       16'hFFFF
`define LEVEL_ALT_DEF   16'h0000
`endif

// ---- hdl/keying_pkg.sv ----
/*
 types of the keying control block.
 assumes nothing of its surroundings.
*/
package keying_pkg;
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_FREQ,
		MODE_PHASE,
		MODE_AMPL
	} mode_e;
	typedef enum logic [2:0] {
		WAVE_SINE,
		WAVE_SQUARE,
		WAVE_RAMP,
		WAVE_TRIANGLE,
		WAVE_ARB,
		WAVE_PULSE,
		WAVE_DC
	} wave_e;
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRESP,
		BUS_RRESP
	} bus_e;
endpackage

// ---- hdl/keying_modulation_control.sv ----
/*
 keying modulation control: registers, mode and carrier checks, rate generator and
 the two-state selection for frequency, phase and amplitude shift keying.
 assumes an axi4-lite master on aclk and a synthesis datapath that follows the outputs.
*/
// Function
// R1: frequency-shift alternates carrier and hop frequency at rate 2 mHz..100 kHz, default 10 Hz
// R2: phase-shift switches between two phases paced by the internal rate generator
// R3: at most one modulation mode enabled at any time
// R4: phase-shift refused while sweep is enabled
// R5: amplitude-shift refused while sweep is enabled
// R6: phase-shift carrier sine/square/ramp/triangle/arb, default sine; pulse and dc rejected
// R7: amplitude-shift carrier sine/square/ramp/triangle/arb, default sine; pulse and dc rejected
// R8: carrier max 20 MHz sine/square, 200 kHz others, default 1 kHz; checked only when carrier or hop is written, not on a wave change
// R9: phase-shift modulating signal is a 50% duty square wave only
// R10: phase-shift rate 2 mHz..100 kHz, default 10 Hz
// R11: phase offset programmable 0..360 degrees, default 180
// R12: amplitude-shift varies only amplitude between two levels, paced by rate generator
// R13: amplitude-shift rate 2 mHz..100 kHz, default 10 Hz
// R14: hop frequency defaults to 100 Hz for every carrier function
// R15: frequency-shift modulating signal is a 50% duty square wave only
// R16: keying disabled returns output to the plain carrier settings
`timescale 1ns/10ps
`include "keying_defines.svh"
module keying_modulation_control (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      out_freq_q,
	output logic [8:0]       out_phase_q,
	output logic [15:0]      out_level_q,
	output logic             shift_state_q
);
	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	keying_pkg::mode_e  mode_q;
	logic               sweep_q;
	keying_pkg::wave_e  wave_q;
	logic [31:0]        carrier_q;
	logic [31:0]        hop_q;
	logic [31:0]        rate_q;
	logic [8:0]         phase_q;
	logic [15:0]        level_q;
	logic [15:0]        level_alt_q;
	logic [5:1]         rej_q;
	keying_pkg::bus_e   bus_q;
	logic               aw_got_q;
	logic               w_got_q;
	logic [4:0]         awaddr_q;
	logic [31:0]        wdata_q;
	logic               wfull_q;
	// ----------------------------------------
	// write address/data capture, either order
	// ----------------------------------------
	wire aw_take = s_axi_awready & s_axi_awvalid;
	wire w_take  = s_axi_wready & s_axi_wvalid;
	wire [4:0]  wa = aw_take ? s_axi_awaddr : awaddr_q;
	wire [31:0] wd = w_take ? s_axi_wdata : wdata_q;
	wire        do_write = (bus_q == keying_pkg::BUS_IDLE) & (aw_got_q | aw_take) & (w_got_q | w_take);
	wire        full_word = w_take ? (s_axi_wstrb == 4'hF) : wfull_q;
	wire        do_read = (bus_q == keying_pkg::BUS_IDLE) & s_axi_arvalid & ~do_write;
	// ----------------------------------------
	// write decode and acceptance checks
	// ----------------------------------------
	wire sel_ctrl    = do_write & (wa == `OFF_CTRL);
	wire sel_wave    = do_write & (wa == `OFF_WAVE);
	wire sel_carrier = do_write & (wa == `OFF_CARRIER);
	wire sel_hop     = do_write & (wa == `OFF_HOP);
	wire sel_rate    = do_write & (wa == `OFF_RATE);
	wire sel_phase   = do_write & (wa == `OFF_PHASE);
	wire sel_level   = do_write & (wa == `OFF_LEVEL);
	wire sel_status  = do_write & (wa == `OFF_STATUS);
	wire mapped_w    = sel_ctrl | sel_wave | sel_carrier | sel_hop | sel_rate | sel_phase | sel_level | sel_status;
	keying_pkg::mode_e new_mode;
	assign new_mode = keying_pkg::mode_e'(wd[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	wire new_sweep   = wd[`CTRL_SWEEP];
	// one mode field means two modes can never be on together
	wire mode_busy   = (new_mode != keying_pkg::MODE_OFF) & new_sweep;             // [R3] [R4] [R5]
	wire keyed_wave_bad = (wave_q == keying_pkg::WAVE_PULSE) | (wave_q == keying_pkg::WAVE_DC);
	wire ctrl_wave_bad  = (new_mode != keying_pkg::MODE_OFF) & keyed_wave_bad;     // [R6] [R7]
	wire ctrl_ok     = ~mode_busy & ~ctrl_wave_bad;
	keying_pkg::wave_e new_wave;
	assign new_wave = keying_pkg::wave_e'(wd[2:0]);
	wire wave_bad    = (wd[2:0] > 3'h6) | (wd[31:3] != 29'h0)
		| ((mode_q != keying_pkg::MODE_OFF) &
		((new_wave == keying_pkg::WAVE_PULSE) | (new_wave == keying_pkg::WAVE_DC))); // [R6] [R7]
	wire fast_wave   = (wave_q == keying_pkg::WAVE_SINE) | (wave_q == keying_pkg::WAVE_SQUARE);
	// the fast limit lies above the 32-bit range, so it is compared at 64 bits
	wire [63:0] fmax = fast_wave ? `FAST_MAX_MHZ : `SLOW_MAX_MHZ;
	wire freq_bad    = (wd == 32'h0) | ({32'h0, wd} > fmax);                        // [R8]
	wire rate_bad    = (wd < `RATE_MIN_MHZ) | (wd > `RATE_MAX_MHZ);                 // [R1] [R10] [R13]
	wire phase_bad   = (wd[8:0] > `PHASE_MAX_DEG) | (wd[31:9] != 23'h0);            // [R11]
	wire any_rej     = (sel_ctrl & ~ctrl_ok) | (sel_wave & wave_bad) | ((sel_carrier | sel_hop) & freq_bad)
		| (sel_rate & rate_bad) | (sel_phase & phase_bad);
	wire wr_err      = ~mapped_w | ~full_word | any_rej;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 5'h00;
			wdata_q  <= 32'h0000_0000;
			wfull_q  <= 1'b0;
		end else begin
			aw_got_q <= ~do_write & (aw_got_q | aw_take);
			w_got_q  <= ~do_write & (w_got_q | w_take);
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wfull_q <= (s_axi_wstrb == 4'hF);
			end
		end
	end
	// ----------------------------------------
	// settings, rejected writes leave them unchanged
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q      <= keying_pkg::MODE_OFF;
			sweep_q     <= 1'b0;
			wave_q      <= keying_pkg::WAVE_SINE;                                   // [R6] [R7]
			carrier_q   <= `CARRIER_DEF_MHZ;                                        // [R8]
			hop_q       <= `HOP_DEF_MHZ;                                            // [R14]
			rate_q      <= `RATE_DEF_MHZ;                                           // [R1] [R10] [R13]
			phase_q     <= `PHASE_DEF_DEG;                                          // [R11]
			level_q     <= `LEVEL_DEF;
			level_alt_q <= `LEVEL_ALT_DEF;
		end else if (do_write & full_word) begin
			if (sel_ctrl & ctrl_ok) begin
				mode_q  <= new_mode;
				sweep_q <= new_sweep;
			end
			if (sel_wave & ~wave_bad)
				wave_q <= new_wave;
			if (sel_carrier & ~freq_bad)
				carrier_q <= wd;
			if (sel_hop & ~freq_bad)
				hop_q <= wd;
			if (sel_rate & ~rate_bad)
				rate_q <= wd;
			if (sel_phase & ~phase_bad)
				phase_q <= wd[8:0];
			if (sel_level) begin
				level_q     <= wd[15:0];
				level_alt_q <= wd[31:16];
			end
		end
	end
	// sticky reject flags, a new reject wins over the write-one clear
	wire [5:1] rej_set = {sel_phase & phase_bad, sel_rate & rate_bad, (sel_carrier | sel_hop) & freq_bad,
		sel_wave & wave_bad, sel_ctrl & ~ctrl_ok};
	wire [5:1] rej_clr = (sel_status & full_word) ? wd[5:1] : 5'h00;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rej_q <= 5'h00;
		else
			rej_q <= (rej_q & ~rej_clr) | (full_word ? rej_set : 5'h00);
	end
	// ----------------------------------------
	// rate generator: phase accumulator, msb is a 50% square
	// ----------------------------------------
	// step = rate * 2^32 / clock, in millihertz; rates below one step per 2^32 cycles floor to 1
	logic [31:0] acc_q;
	wire [63:0]  step_wide = ({32'h0, rate_q} << 32) / `CLK_MHZ_UNITS;
	wire [31:0]  step = (step_wide[31:0] == 32'h0) ? 32'h1 : step_wide[31:0];
	wire [31:0]  acc_d = acc_q + step;
	wire         keying = (mode_q != keying_pkg::MODE_OFF);
	always_ff @(posedge aclk) begin
		if (!aresetn | ~keying)
			acc_q <= 32'h0000_0000;
		else
			acc_q <= acc_d;                                                         // [R9] [R15]
	end
	// ----------------------------------------
	// output selection
	// ----------------------------------------
	wire shift = keying & acc_q[31];                                                // [R2] [R12]
	wire freq_keyed  = shift & (mode_q == keying_pkg::MODE_FREQ);                   // [R1] [R16]
	wire phase_keyed = shift & (mode_q == keying_pkg::MODE_PHASE);                  // [R2] [R16]
	wire level_keyed = shift & (mode_q == keying_pkg::MODE_AMPL);                   // [R12] [R16]
	keyed_output #(
		.WIDTH       (32),
		.RESET_VALUE (`CARRIER_DEF_MHZ)
	) freq_out_i (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.shifted    (freq_keyed),
		.base_value (carrier_q),
		.alt_value  (hop_q),
		.out_q      (out_freq_q)
	);
	keyed_output #(
		.WIDTH       (9),
		.RESET_VALUE (9'h000)
	) phase_out_i (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.shifted    (phase_keyed),
		.base_value (9'h000),
		.alt_value  (phase_q),
		.out_q      (out_phase_q)
	);
	keyed_output #(
		.WIDTH       (16),
		.RESET_VALUE (`LEVEL_DEF)
	) level_out_i (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.shifted    (level_keyed),
		.base_value (level_q),
		.alt_value  (level_alt_q),
		.out_q      (out_level_q)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			shift_state_q <= 1'b0;
		else
			shift_state_q <= shift;
	end
	// ----------------------------------------
	// axi4-lite handshake and read mux
	// ----------------------------------------
	wire [31:0] status_word = {26'h0, rej_q, sweep_q};
	wire [31:0] ctrl_word   = {27'h0, sweep_q, 2'b00, mode_q};
	wire [4:0]  ra = s_axi_araddr;
	wire        rd_hit = (ra == `OFF_CTRL) | (ra == `OFF_WAVE) | (ra == `OFF_CARRIER) | (ra == `OFF_HOP)
		| (ra == `OFF_RATE) | (ra == `OFF_PHASE) | (ra == `OFF_LEVEL) | (ra == `OFF_STATUS);
	wire [31:0] rd_word =
		(ra == `OFF_CTRL)    ? ctrl_word :
		(ra == `OFF_WAVE)    ? {29'h0, wave_q} :
		(ra == `OFF_CARRIER) ? carrier_q :
		(ra == `OFF_HOP)     ? hop_q :
		(ra == `OFF_RATE)    ? rate_q :
		(ra == `OFF_PHASE)   ? {23'h0, phase_q} :
		(ra == `OFF_LEVEL)   ? {level_alt_q, level_q} :
		(ra == `OFF_STATUS)  ? status_word : 32'h0000_0000;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_q         <= keying_pkg::BUS_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'b00;
			s_axi_rdata   <= 32'h0000_0000;
		end else begin
			s_axi_arready <= 1'b0;
			case (bus_q)
				keying_pkg::BUS_IDLE: begin
					s_axi_awready <= ~(aw_got_q | aw_take) & ~do_write;
					s_axi_wready  <= ~(w_got_q | w_take) & ~do_write;
					if (do_write) begin
						bus_q        <= keying_pkg::BUS_WRESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_err ? 2'b10 : 2'b00;
					end else if (do_read) begin
						bus_q         <= keying_pkg::BUS_RRESP;
						s_axi_arready <= 1'b1;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_word;
						s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
					end
				end
				keying_pkg::BUS_WRESP: begin
					s_axi_awready <= 1'b0;
					s_axi_wready  <= 1'b0;
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						bus_q        <= keying_pkg::BUS_IDLE;
					end
				end
				keying_pkg::BUS_RRESP: begin
					s_axi_awready <= 1'b0;
					s_axi_wready  <= 1'b0;
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						bus_q        <= keying_pkg::BUS_IDLE;
					end
				end
				default: begin
					bus_q <= keying_pkg::BUS_IDLE;
				end
			endcase
		end
	end
endmodule

// ----------------------------------------
// one keyed output: base value, or the alternate in the shifted half
// ----------------------------------------
// registered here so that each top-level output still comes straight from a flop
module keyed_output #(
	parameter int               WIDTH       = 32,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             shifted,
	input  wire logic [WIDTH-1:0] base_value,
	input  wire logic [WIDTH-1:0] alt_value,
	output logic      [WIDTH-1:0] out_q
);
	wire [WIDTH-1:0] out_d = shifted ? alt_value : base_value;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			out_q <= RESET_VALUE;
		else
			out_q <= out_d;
	end
endmodule

// ---- test/keying_monitor.sv ----
/*
 checker of the keying control block, watching its ports only.
 assumes one clock, aclk, and a synchronous active-low aresetn.
*/
`timescale 1ns/10ps
module keying_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] out_freq_q,
	input wire logic [8:0]  out_phase_q,
	input wire logic [15:0] out_level_q,
	input wire logic        shift_state_q
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_defaults: assert property ($rose(aresetn) |-> out_freq_q == 32'h000F4240 && out_phase_q == 9'h000 &&
		out_level_q == 16'hFFFF && !shift_state_q) else $error("outputs not at defaults after reset");
	a_phase_unshifted: assert property (!shift_state_q |-> out_phase_q == 9'h000)
		else $error("phase offset outside shifted half");
	a_phase_range: assert property (out_phase_q <= 9'h168) else $error("phase offset above 360");
	// one mode at a time: a toggle may move only one of the three outputs
	a_one_output_keys: assert property ($changed(shift_state_q) |->
		({1'b0, $changed(out_freq_q)} + {1'b0, $changed(out_phase_q)} + {1'b0, $changed(out_level_q)}) <= 2'h1)
		else $error("more than one output keyed");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during response");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_read_pulse: assert property ($rose(s_axi_rvalid) |-> s_axi_arready ##1 !s_axi_arready)
		else $error("arready not a pulse");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
bind keying_modulation_control keying_monitor keying_monitor_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.out_freq_q, .out_phase_q, .out_level_q, .shift_state_q);

// ---- test/host_model.sv ----
/*
 host software model: an axi4-lite master doing single register transfers.
 assumes the keying block as slave on the same aclk.
*/
`timescale 1ns/10ps
module host_model (
	input  wire logic        aclk,
	output logic      [4:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [4:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// address and data leave independently, each once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ---- test/tb_keying_modulation_control.sv ----
/*
 self-checking bench of the keying control block against a register model.
 assumes host_model as bus master and keying_monitor bound to the design.
*/
`timescale 1ns/10ps
module tb_keying_modulation_control;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, shift_state_q;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, out_freq_q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [8:0]  out_phase_q;
	logic [15:0] out_level_q;
	int          num_errors = 0, compares = 0;
	int          rej_bit [8] = '{1, 2, 3, 3, 4, 5, 0, 0};
	logic [31:0] msk [8] = '{32'h13, 32'h7, '1, '1, '1, 32'h1FF, '1, '1};
	logic [31:0] exp_reg [8] = '{0, 0, 32'h000F4240, 32'h000186A0, 32'h2710, 32'hB4, 32'hFFFF, 0};
	logic [31:0] tbl [22][2] = '{'{4, 1}, '{4, 32'h5F5E101}, '{4, 2}, '{4, 32'h5F5E100}, '{5, 32'h169},
		'{5, 32'h168}, '{0, 32'h12}, '{0, 32'h13}, '{0, 32'h11}, '{1, 5}, '{0, 2}, '{1, 6}, '{0, 3}, '{1, 2},
		'{2, 32'hBEBC201}, '{2, 32'hBEBC200}, '{0, 2}, '{1, 5}, '{0, 3}, '{0, 0}, '{0, 32'h10}, '{0, 0}};
	keying_modulation_control keying_modulation_control_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .out_freq_q, .out_phase_q, .out_level_q, .shift_state_q);
	host_model host_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ----------------------------------------
	// model and checks
	// ----------------------------------------
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic bit accepts(int i, logic [31:0] v);
		case (i)
			0: return v[1:0] == 0 || (!v[4] && exp_reg[1] < 5);
			1: return v < 7 && (v < 5 || exp_reg[0][1:0] == 0);
			2, 3: return v != 0 && (exp_reg[1] < 2 || v <= 32'hBEBC200);
			4: return v >= 2 && v <= 32'h5F5E100;
			5: return v <= 32'h168;
			default: return 1'b1;
		endcase
	endfunction
	task automatic put(input int i, input logic [31:0] v, input logic [3:0] s = 4'hF);
		logic [1:0] r;
		bit ok;
		ok = s == 4'hF && accepts(i, v);
		host_model_i.wr(5'(i * 4), v, s, r);
		check("bresp", 32'(r), ok ? 32'h0 : 32'h2);
		if (ok && i == 7)
			exp_reg[7] = exp_reg[7] & ~(v & 32'h3E);
		else if (ok)
			exp_reg[i] = v & msk[i];
		else if (s == 4'hF)
			exp_reg[7][rej_bit[i]] = 1'b1;
		exp_reg[7][0] = exp_reg[0][4];
	endtask
	task automatic read_all();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 8; i++) begin
			host_model_i.rd(5'(i * 4), d, r);
			check("rdata", d, exp_reg[i]);
			check("rresp", 32'(r), 32'h0);
		end
	endtask
	// a 400-cycle window at 100 kHz holds about eight toggles
	task automatic keying(input int m);
		int bad = 0, tog = 0, hi = 0;
		logic prev;
		put(0, m);
		repeat (3) @(posedge aclk);
		prev = shift_state_q;
		repeat (400) begin
			@(posedge aclk);
			tog += int'(shift_state_q != prev);
			hi += int'(shift_state_q);
			prev = shift_state_q;
			bad += int'(out_freq_q !== ((m == 1 && shift_state_q) ? exp_reg[3] : exp_reg[2]));
			bad += int'(out_phase_q !== ((m == 2 && shift_state_q) ? exp_reg[5][8:0] : 9'h000));
			bad += int'(out_level_q !== ((m == 3 && shift_state_q) ? exp_reg[6][31:16] : exp_reg[6][15:0]));
		end
		check("keyed outputs", 32'(bad), 32'h0);
		check("toggle count", 32'(tog >= 7 && tog <= 9), 32'h1);
		check("high share", 32'(hi >= 150 && hi <= 250), 32'h1);
		put(0, 0);
		repeat (2) @(posedge aclk);
		check("plain carrier", {out_freq_q, out_phase_q, out_level_q, shift_state_q},
			{exp_reg[2], 9'h000, exp_reg[6][15:0], 1'b0});
		$display("test keying mode %0d done", m);
	endtask
	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		end_of_test();
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		aresetn = 1'b0;
		void'($urandom(32'h0A79));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		read_all();
		$display("test defaults done");
		foreach (tbl[k]) put(tbl[k][0], tbl[k][1]);
		put(5, $urandom_range(360));
		put(2, $urandom_range(32'hBEBC200, 32'h3E8));
		put(3, 32'h4C4B40);
		put(6, $urandom);
		read_all();
		$display("test settings done");
		for (int m = 1; m < 4; m++) keying(m);
		put(5, 32'h5A, 4'h3);
		put(7, 32'h3E);
		read_all();
		host_model_i.rd(5'h02, d, r);
		check("unmapped rdata", d, 32'h0);
		check("unmapped rresp", 32'(r), 32'h2);
		host_model_i.wr(5'h1E, 32'h0, 4'hF, r);
		check("unmapped bresp", 32'(r), 32'h2);
		$display("test status and unmapped done");
		end_of_test();
	end
endmodule
